// [hdl/mctmr_top.sv]
// Match/capture timer: prescaler, counter, match, capture, pins, DMA, AHB-Lite registers
`timescale 1ns/1ps
`include "mctmr_regs.svh"
// What this block does
// [RQ1] Timer mode or external counter mode
// [RQ2] 32-bit counter behind 32-bit prescaler
// [RQ3] Prescaler wraps at limit, counter steps
// [RQ4] Two captures snapshot counter on edge
// [RQ5] Capture interrupt per channel enable
// [RQ6] Four match registers compared for equality
// [RQ7] Continue on match, optional interrupt
// [RQ8] Stop on match, optional interrupt
// [RQ9] Reset counter on match, optional interrupt
// [RQ10] Four match outputs, one per match
// [RQ11] Output low, high, toggle or keep
// [RQ12] Two matches raise timed DMA requests
module mctmr_top
#(
  parameter int NMATCH = 4,
  parameter int NCAP = 2,
  parameter int NDMA = 2
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // External pins
  input wire logic COUNT_PIN,
  input wire logic [NCAP-1:0] CAP_PIN,
  output logic [NMATCH-1:0] MATCH_OUT,
  // Requests
  output logic [NDMA-1:0] DMA_REQ,
  output logic IRQ
);
  localparam int NEV = NMATCH + NCAP; // Status width
  // Bus phase capture
  logic wr_pend_q; // Write data phase pending
  logic [11:0] waddr_q; // Latched write address
  logic [31:0] rdata_q; // Read data register
  // Registers
  logic [31:0] ctrl_q; // Run, counter reset, mode, count edge
  logic [31:0] count_q; // Main counter
  logic [31:0] count_d;
  logic [31:0] prelim_q; // Prescale limit
  logic [31:0] precnt_q; // Prescale counter
  logic [31:0] precnt_d;
  logic [31:0] match_q [NMATCH]; // Match values
  logic [31:0] mact_q; // Per match: 3 bits {stop,reset,irq}
  logic [31:0] cap_q [NCAP]; // Capture snapshots
  logic [31:0] capcfg_q; // Per channel: 3 bits {irq,edge}
  logic [31:0] outcfg_q; // Per pin: 2 bits action
  logic [NMATCH-1:0] outlvl_q; // Match pin levels
  logic [NDMA-1:0] dmacfg_q; // DMA enable per match 0..1
  logic [NDMA-1:0] dma_q; // Registered DMA pulses
  logic [NEV-1:0] stat_q; // Sticky events
  logic [NEV-1:0] mask_q; // Interrupt mask
  // Decode
  wire acc = HSEL & HREADY & HTRANS[1];
  wire rd_acc = acc & ~HWRITE;
  wire [11:0] a = HADDR[11:0];
  wire [11:0] wa = waddr_q;
  wire wen = wr_pend_q;
  wire ctrl_we = wen && wa == `MCTMR_OFF_CTRL;
  wire count_we = wen && wa == `MCTMR_OFF_COUNT;
  wire prelim_we = wen && wa == `MCTMR_OFF_PRELIM;
  wire precnt_we = wen && wa == `MCTMR_OFF_PRECNT;
  wire mact_we = wen && wa == `MCTMR_OFF_MACT;
  wire capcfg_we = wen && wa == `MCTMR_OFF_CAPCFG;
  wire outcfg_we = wen && wa == `MCTMR_OFF_OUTCFG;
  wire outlvl_we = wen && wa == `MCTMR_OFF_OUTLVL;
  wire dmacfg_we = wen && wa == `MCTMR_OFF_DMACFG;
  wire stat_we = wen && wa == `MCTMR_OFF_STAT;
  wire mask_we = wen && wa == `MCTMR_OFF_MASK;
  // Counting control
  wire run = ctrl_q[`MCTMR_CTRL_RUN];
  wire crst = ctrl_q[`MCTMR_CTRL_CRST];
  wire ext_mode = ctrl_q[`MCTMR_CTRL_MODE];
  wire cnt_hit; // External count edge
  wire tick = ext_mode ? cnt_hit : 1'b1; // [RQ1]
  wire pre_wrap = precnt_q == prelim_q; // [RQ3]
  wire step = run & ~crst & tick;
  wire [NMATCH-1:0] mhit; // Equality per match
  wire [NMATCH-1:0] mev; // Match event, once per counter step
  wire [NCAP-1:0] cev; // Capture events
  wire any_stop;
  wire any_reset;
  // Bus answer: zero wait, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;
  // External count input synchroniser
  mctmr_sync u_cnt
  (
    .clk(MCLK),
    .rst(RST),
    .pin(COUNT_PIN),
    .edge_sel(mctmr_pkg::mctmr_edge_t'(ctrl_q[`MCTMR_CTRL_EDGE_LO+:2])),
    .hit(cnt_hit)
  );
  // Per-match compare and actions
  genvar g;
  generate
    for (g = 0; g < NMATCH; g++)
    begin : g_match
      // Equality check against the counter
      assign mhit[g] = count_q == match_q[g]; // [RQ6]
      // Fire when counting would leave the matched value, so a stopped counter never fires
      assign mev[g] = mhit[g] & step & pre_wrap;
      // Match register storage
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
          match_q[g] <= `MCTMR_RST_WORD;
        else if (wen && wa == `MCTMR_OFF_MATCH0 + 12'(4 * g))
          match_q[g] <= HWDATA;
      end
      // Pin action on match
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
          outlvl_q[g] <= 1'b0;
        else if (mev[g])
        begin
          case (mctmr_pkg::mctmr_pin_t'(outcfg_q[2*g+:2])) // [RQ11]
            mctmr_pkg::MCTMR_PIN_LOW: outlvl_q[g] <= 1'b0;
            mctmr_pkg::MCTMR_PIN_HIGH: outlvl_q[g] <= 1'b1;
            mctmr_pkg::MCTMR_PIN_TOGGLE: outlvl_q[g] <= ~outlvl_q[g];
            default: outlvl_q[g] <= outlvl_q[g];
          endcase
        end
        else if (outlvl_we)
          outlvl_q[g] <= HWDATA[g];
      end
    end
  endgenerate
  assign MATCH_OUT = outlvl_q; // [RQ10]
  // Stop and reset actions gathered from all matches
  logic [NMATCH-1:0] stop_v;
  logic [NMATCH-1:0] reset_v;
  generate
    for (g = 0; g < NMATCH; g++)
    begin : g_act
      assign stop_v[g] = mev[g] & mact_q[3*g+2]; // [RQ8]
      assign reset_v[g] = mev[g] & mact_q[3*g+1]; // [RQ9]
    end
  endgenerate
  assign any_stop = |stop_v;
  assign any_reset = |reset_v;
  // Capture channels
  generate
    for (g = 0; g < NCAP; g++)
    begin : g_cap
      mctmr_sync u_cap
      (
        .clk(MCLK),
        .rst(RST),
        .pin(CAP_PIN[g]),
        .edge_sel(mctmr_pkg::mctmr_edge_t'(capcfg_q[3*g+:2])),
        .hit(cev[g])
      );
      // Snapshot counter on transition
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
          cap_q[g] <= `MCTMR_RST_WORD;
        else if (cev[g])
          cap_q[g] <= count_q; // [RQ4]
      end
    end
  endgenerate
  // Next prescale and counter values
  always_comb
  begin
    precnt_d = precnt_q;
    count_d = count_q;
    if (crst)
    begin
      precnt_d = 32'h0000_0000;
      count_d = 32'h0000_0000;
    end
    else if (step)
    begin
      if (pre_wrap)
      begin
        precnt_d = 32'h0000_0000; // [RQ3]
        // Reset action wins over a plain step
        count_d = any_reset ? 32'h0000_0000 : count_q + 32'h0000_0001; // [RQ2] [RQ9]
      end
      else
        precnt_d = precnt_q + 32'h0000_0001; // [RQ3]
    end
    if (precnt_we)
      precnt_d = HWDATA;
    if (count_we)
      count_d = HWDATA;
  end
  // Counter and prescaler registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      count_q <= `MCTMR_RST_WORD;
      precnt_q <= `MCTMR_RST_WORD;
    end
    else
    begin
      count_q <= count_d;
      precnt_q <= precnt_d;
    end
  end
  // Control: stop clears run; a write in the same cycle yields to the stop
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      ctrl_q <= `MCTMR_RST_CTRL;
    else if (any_stop)
      ctrl_q <= {ctrl_q[31:1], 1'b0}; // [RQ8]
    else if (ctrl_we)
      ctrl_q <= HWDATA;
  end
  // Plain configuration registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      prelim_q <= `MCTMR_RST_WORD;
      mact_q <= `MCTMR_RST_WORD;
      capcfg_q <= `MCTMR_RST_WORD;
      outcfg_q <= `MCTMR_RST_WORD;
      dmacfg_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      if (prelim_we)
        prelim_q <= HWDATA;
      if (mact_we)
        mact_q <= HWDATA;
      if (capcfg_we)
        capcfg_q <= HWDATA;
      if (outcfg_we)
        outcfg_q <= HWDATA;
      if (dmacfg_we)
        dmacfg_q <= HWDATA[NDMA-1:0];
      if (mask_we)
        mask_q <= HWDATA[NEV-1:0];
    end
  end
  // Event sources gated by their interrupt enables
  logic [NEV-1:0] ev_set;
  generate
    for (g = 0; g < NMATCH; g++)
    begin : g_mev
      assign ev_set[g] = mev[g] & mact_q[3*g]; // [RQ7] [RQ8] [RQ9]
    end
    for (g = 0; g < NCAP; g++)
    begin : g_cev
      assign ev_set[`MCTMR_STAT_CAP_LO+g] = cev[g] & capcfg_q[3*g+2]; // [RQ5]
    end
  endgenerate
  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      stat_q <= '0;
    else
      stat_q <= (stat_q & ~(stat_we ? HWDATA[NEV-1:0] : '0)) | ev_set;
  end
  assign IRQ = |(stat_q & mask_q);
  // One-cycle DMA request per enabled match
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      dma_q <= '0;
    else
      dma_q <= mev[NDMA-1:0] & dmacfg_q; // [RQ12]
  end
  assign DMA_REQ = dma_q;
  // Bus address phase capture
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      wr_pend_q <= 1'b0;
      waddr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= acc & HWRITE;
      waddr_q <= a;
    end
  end
  // Read mux, unmapped reads as zero
  logic [31:0] rmux;
  always_comb
  begin
    case (a)
      `MCTMR_OFF_CTRL: rmux = ctrl_q;
      `MCTMR_OFF_COUNT: rmux = count_q;
      `MCTMR_OFF_PRELIM: rmux = prelim_q;
      `MCTMR_OFF_PRECNT: rmux = precnt_q;
      `MCTMR_OFF_MATCH0: rmux = match_q[0];
      `MCTMR_OFF_MATCH1: rmux = match_q[1];
      `MCTMR_OFF_MATCH2: rmux = match_q[2];
      `MCTMR_OFF_MATCH3: rmux = match_q[3];
      `MCTMR_OFF_MACT: rmux = mact_q;
      `MCTMR_OFF_CAP0: rmux = cap_q[0];
      `MCTMR_OFF_CAP1: rmux = cap_q[1];
      `MCTMR_OFF_CAPCFG: rmux = capcfg_q;
      `MCTMR_OFF_OUTCFG: rmux = outcfg_q;
      `MCTMR_OFF_OUTLVL: rmux = 32'(outlvl_q);
      `MCTMR_OFF_DMACFG: rmux = 32'(dmacfg_q);
      `MCTMR_OFF_STAT: rmux = 32'(stat_q);
      `MCTMR_OFF_MASK: rmux = 32'(mask_q);
      default: rmux = 32'h0000_0000;
    endcase
  end
  // Read data registered at end of address phase
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      rdata_q <= 32'h0000_0000;
    else if (rd_acc)
      rdata_q <= rmux;
  end
endmodule

// [hdl/mctmr_regs.svh]
// Register offsets, field positions and reset values of the match/capture timer
`ifndef MCTMR_REGS_SVH
`define MCTMR_REGS_SVH
// Register byte offsets
`define MCTMR_OFF_CTRL 12'h000
`define MCTMR_OFF_COUNT 12'h004
`define MCTMR_OFF_PRELIM 12'h008
`define MCTMR_OFF_PRECNT 12'h00c
`define MCTMR_OFF_MATCH0 12'h010
`define MCTMR_OFF_MATCH1 12'h014
`define MCTMR_OFF_MATCH2 12'h018
`define MCTMR_OFF_MATCH3 12'h01c
`define MCTMR_OFF_MACT 12'h020
`define MCTMR_OFF_CAP0 12'h024
`define MCTMR_OFF_CAP1 12'h028
`define MCTMR_OFF_CAPCFG 12'h02c
`define MCTMR_OFF_OUTCFG 12'h030
`define MCTMR_OFF_OUTLVL 12'h034
`define MCTMR_OFF_DMACFG 12'h038
`define MCTMR_OFF_STAT 12'h03c
`define MCTMR_OFF_MASK 12'h040
// Control fields
`define MCTMR_CTRL_RUN 0
`define MCTMR_CTRL_CRST 1
`define MCTMR_CTRL_MODE 2
`define MCTMR_CTRL_EDGE_LO 3
// Status bit positions: match 0..3, capture 4..5
`define MCTMR_STAT_CAP_LO 4
// Reset values
`define MCTMR_RST_CTRL 32'h0000_0000
`define MCTMR_RST_WORD 32'h0000_0000
`endif

// [hdl/mctmr_pkg.sv]
// Types shared by the match/capture timer files
package mctmr_pkg;
  // Edge choice for capture channels and external count input
  typedef enum logic [1:0] {
    MCTMR_EDGE_NONE = 2'b00,
    MCTMR_EDGE_RISE = 2'b01,
    MCTMR_EDGE_FALL = 2'b10,
    MCTMR_EDGE_BOTH = 2'b11
  } mctmr_edge_t;
  // Pin action on match
  typedef enum logic [1:0] {
    MCTMR_PIN_KEEP = 2'b00,
    MCTMR_PIN_LOW = 2'b01,
    MCTMR_PIN_HIGH = 2'b10,
    MCTMR_PIN_TOGGLE = 2'b11
  } mctmr_pin_t;
endpackage

// [hdl/mctmr_sync.sv]
// Three-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module mctmr_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and edge choice
  input wire logic pin,
  input wire mctmr_pkg::mctmr_edge_t edge_sel,
  // Event out
  output logic hit
);
  logic s1_q; // Metastability stage, read by s2 only
  logic s2_q; // Second stage
  logic s3_q; // Third stage
  logic lvl_q; // Level last agreed by stages two and three
  wire agree; // Stages two and three hold the same level
  wire rise; // Stages agree high after low
  wire fall; // Stages agree low after high
  // Shift chain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A one-cycle glitch never reaches agreement, so it is not counted
      if (agree)
        lvl_q <= s3_q;
    end
  end
  assign agree = s2_q == s3_q;
  // Count a change once both late stages show the new level
  assign rise = agree & s3_q & ~lvl_q;
  assign fall = agree & ~s3_q & lvl_q;
  // Edge choice decides which transitions count
  assign hit = (rise & edge_sel[0]) | (fall & edge_sel[1]);
endmodule

// [verif/mctmr_pins.sv]
// Far-side pin model driving the count and capture inputs
`timescale 1ns/1ps
module mctmr_pins
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pulse requests: count, capture 0, capture 1
  input wire logic [2:0] go,
  // Pins
  output logic cnt,
  output logic [1:0] cap
);
  logic [3:0] s0; // Count pin history
  logic [3:0] s1; // Capture 0 history
  logic [3:0] s2; // Capture 1 history
  // Four-cycle high level, safely above the two-cycle minimum per level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s0 <= '0;
      s1 <= '0;
      s2 <= '0;
    end
    else
    begin
      s0 <= {s0[2:0], go[0]};
      s1 <= {s1[2:0], go[1]};
      s2 <= {s2[2:0], go[2]};
    end
  end
  // Driven low between pulses
  assign cnt = |s0;
  assign cap = {|s2, |s1};
endmodule

// [verif/mctmr_top_sva.sv]
// Port checker of the match/capture timer
`timescale 1ns/1ps
`include "mctmr_regs.svh"
module mctmr_top_sva
#(
  parameter int NMATCH = 4,
  parameter int NCAP = 2,
  parameter int NDMA = 2
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Pins and requests
  input wire logic [NMATCH-1:0] MATCH_OUT,
  input wire logic [NDMA-1:0] DMA_REQ,
  input wire logic IRQ
);
  logic act; // Transfer taken at this edge
  logic w_q; // Write data phase
  logic [11:0] a_q; // Address of the data phase
  logic run_q; // Last written run bit; stop on match not seen, so only weakens checks
  logic [NDMA-1:0] dma_q; // Last written DMA enables
  logic [5:0] msk_q; // Last written mask
  assign act = HSEL && HREADY && HTRANS[1];
  // Shadow of the writes the checks rely on
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      w_q <= 1'b0;
      a_q <= '0;
      run_q <= 1'b0;
      dma_q <= '0;
      msk_q <= '0;
    end
    else
    begin
      w_q <= act && HWRITE;
      a_q <= HADDR[11:0];
      if (w_q && a_q == `MCTMR_OFF_CTRL)
        run_q <= HWDATA[`MCTMR_CTRL_RUN];
      if (w_q && a_q == `MCTMR_OFF_DMACFG)
        dma_q <= HWDATA[NDMA-1:0];
      if (w_q && a_q == `MCTMR_OFF_MASK)
        msk_q <= HWDATA[5:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Pin level write while stopped: address then data phase
  sequence s_lvl_wr;
    (act && HWRITE && HADDR[11:0] == `MCTMR_OFF_OUTLVL && !run_q) ##1 !run_q;
  endsequence
  a_bus_ready: assert property (HREADYOUT == 1'b1)
    else $error("bus slave inserted a wait state");
  a_bus_okay: assert property (HRESP == 1'b0)
    else $error("bus slave gave an error response");
  a_quiet_reset: assert property ($fell(RST) |-> MATCH_OUT == '0 && DMA_REQ == '0 && !IRQ)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (act && !HWRITE && HADDR[11:0] > `MCTMR_OFF_MASK |=> HRDATA == '0)
    else $error("unmapped read not zero");
  a_level_write: assert property (s_lvl_wr |=> MATCH_OUT == $past(HWDATA[NMATCH-1:0]))
    else $error("pin level write lost");
  a_stopped_no_dma: assert property (!run_q && !$past(run_q) |-> DMA_REQ == '0)
    else $error("DMA request while stopped");
  a_dma_enabled: assert property ((DMA_REQ & ~dma_q & ~$past(dma_q)) == '0)
    else $error("DMA request from a disabled match");
  a_irq_masked: assert property (IRQ |-> msk_q != '0)
    else $error("interrupt with all sources masked");
endmodule
bind mctmr_top mctmr_top_sva #(.NMATCH(NMATCH), .NCAP(NCAP), .NDMA(NDMA)) u_sva (.*);

// [verif/match_capture_timer_tb_top.sv]
// Self-checking bench of the match/capture timer
`timescale 1ns/1ps
module match_capture_timer_tb_top;
  logic MCLK = 1'b0; // Clock
  logic RST = 1'b1; // Reset
  logic [31:0] haddr = '0; // Bus address
  logic [1:0] htrans = '0; // Bus transfer kind
  logic hwrite = 1'b0; // Bus direction
  logic [31:0] hwdata = '0; // Bus write data
  logic [31:0] hrdata; // Bus read data
  logic hready; // Bus ready
  logic [2:0] go = '0; // Pin pulse requests
  logic count_pin; // Count input
  logic [1:0] cap_pin; // Capture inputs
  logic [3:0] match_out; // Match pins
  logic [1:0] dma_req; // DMA pulses
  logic irq; // Interrupt
  logic [31:0] r; // Last read data
  logic [31:0] hold; // Saved count
  logic [11:0] ra [8]; // Row address
  logic [31:0] rw [8]; // Row write data
  logic [31:0] re [8]; // Row expected read
  int n_errors = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int cyc = 0; // Cycle count
  int n_dma0 = 0; // DMA 0 pulses
  int n_dma1 = 0; // DMA 1 pulses
  mctmr_top u_dut (.MCLK(MCLK), .RST(RST), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .COUNT_PIN(count_pin), .CAP_PIN(cap_pin),
    .MATCH_OUT(match_out), .DMA_REQ(dma_req), .IRQ(irq));
  mctmr_pins u_pins (.clk(MCLK), .rst(RST), .go(go), .cnt(count_pin), .cap(cap_pin));
  // 125 MHz clock
  always #4 MCLK = ~MCLK;
  // Pulse counters and hang guard
  always @(posedge MCLK)
  begin
    cyc++;
    n_dma0 += dma_req[0];
    n_dma1 += dma_req[1];
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  // One single bus transfer; no wait count assumed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge MCLK); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge MCLK); while (hready !== 1'b1);
    r = hrdata;
    // Let register updates of this edge settle before any output is looked at
    @(negedge MCLK);
  endtask
  // Read and compare
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask
  // One pulse on a pin, then enough time for synchroniser and capture
  task automatic pulse(input int i);
    @(posedge MCLK);
    go <= 3'b001 << i;
    @(posedge MCLK);
    go <= '0;
    repeat (12) @(posedge MCLK);
  endtask
  // Verdict
  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    ra = '{12'h008, 12'h004, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h024, 12'h044};
    rw = '{32'hffff_ffff, 32'h8000_0001, 32'h1111_1111, 32'h2222_2222, 32'h3333_3333,
      32'h4444_4444, 32'h1234_5678, 32'h5555_aaaa};
    re = '{32'hffff_ffff, 32'h8000_0001, 32'h1111_1111, 32'h2222_2222, 32'h3333_3333,
      32'h4444_4444, 32'h0, 32'h0};
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    chk("idle", {25'h0, irq, dma_req, match_out}, 32'h0);
    rdc("ctrl", 12'h000, 32'h0);
    // Full-width registers, read-only capture, unmapped place
    for (int k = 0; k < 8; k++)
    begin
      xfer(1'b1, ra[k], rw[k]);
      rdc("row", ra[k], re[k]);
    end
    // Timer mode, prescale limit 2: 33 clocks give 11 steps
    xfer(1'b1, 12'h008, 32'h2);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h00c, 32'h0);
    xfer(1'b1, 12'h000, 32'h1);
    repeat (30) @(posedge MCLK);
    xfer(1'b1, 12'h000, 32'h0);
    rdc("count", 12'h004, 32'd11);
    rdc("prescale", 12'h00c, 32'h0);
    // Reset on match 3, continue on 2, pin high on 1, toggle/low/keep, DMA on match 0
    xfer(1'b1, 12'h008, 32'h0);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h010, 32'h3);
    xfer(1'b1, 12'h014, 32'h1);
    xfer(1'b1, 12'h018, 32'h2);
    xfer(1'b1, 12'h020, 32'h43);
    xfer(1'b1, 12'h030, 32'h1b);
    xfer(1'b1, 12'h034, 32'h4);
    xfer(1'b1, 12'h038, 32'h1);
    n_dma0 = 0;
    n_dma1 = 0;
    xfer(1'b1, 12'h000, 32'h1);
    repeat (26) @(posedge MCLK);
    xfer(1'b1, 12'h000, 32'h0);
    rdc("wrap", 12'h004, 32'h1);
    chk("dma0", n_dma0, 32'd7);
    chk("dma1", n_dma1, 32'd0);
    chk("pins", {28'h0, match_out}, 32'h3);
    rdc("stat", 12'h03c, 32'h5);
    chk("masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, 12'h040, 32'h4);
    chk("irq", {31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h03c, 32'h5);
    chk("clear", {31'h0, irq}, 32'h0);
    // Stop on match 5 with interrupt
    xfer(1'b1, 12'h014, 32'h5);
    xfer(1'b1, 12'h020, 32'h28);
    xfer(1'b1, 12'h040, 32'h2);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h000, 32'h1);
    repeat (20) @(posedge MCLK);
    rdc("run", 12'h000, 32'h0);
    xfer(1'b0, 12'h004, 32'h0);
    hold = r;
    repeat (5) @(posedge MCLK);
    rdc("held", 12'h004, hold);
    chk("stopirq", {31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h03c, 32'h3f);
    // Counter mode on rising count edges, capture 0 rise with irq, capture 1 fall without
    xfer(1'b1, 12'h020, 32'h0);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h040, 32'h30);
    xfer(1'b1, 12'h02c, 32'h15);
    xfer(1'b1, 12'h000, 32'h0d);
    repeat (5) pulse(0);
    pulse(1);
    rdc("cap0", 12'h024, 32'h5);
    chk("capirq", {31'h0, irq}, 32'h1);
    pulse(2);
    rdc("cap1", 12'h028, 32'h5);
    xfer(1'b1, 12'h03c, 32'h10);
    chk("capoff", {31'h0, irq}, 32'h0);
    // Counter reset bit holds the counter at zero while running
    xfer(1'b1, 12'h000, 32'h3);
    repeat (4) @(posedge MCLK);
    rdc("crst", 12'h004, 32'h0);
    // Mid-run reset: outputs, control and capture return to zero
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    chk("rst_out", {25'h0, irq, dma_req, match_out}, 32'h0);
    rdc("rst_ctrl", 12'h000, 32'h0);
    rdc("rst_cap", 12'h024, 32'h0);
    results();
  end
endmodule
